/* common/serial_spi_pkg.sv */
// Operation
// - One byte register holds the outgoing and the incoming byte, shared by both modes.
// - Mode codes 000, 001, 010 select master with clock divided by 4, 16, 64.
// - Code 011 clocks master from subsystem clock; 100 from half the timer match rate.
// - Code 101 is SPI slave, 110 is I2C slave, 111 disables the interface.
// - Mode field in bits 7 to 5 resets to ones; bit 4 reads zero.
// - Debounce field: 00 none, 01 two clocks, 1x four clocks.
// - Enable low removes pin functions and minimises current; high enables.
// - Enabling in SPI mode keeps the SPI control register contents.
// - Enabling in I2C mode keeps direction and acknowledge bits, resets I2C flags.
// - Slave select rising mid-transfer sets incomplete and complete flags together.
// - Incomplete flag applies to slave mode only and raises the event request.
// - Software setting the incomplete flag does not set the complete flag.
// - SPI logic ignores the I2C auxiliary control register.
// - Format register holds order, collision, complete, select enable, polarity, edge.
// - Select enable one gives the select pin its function; zero leaves it floating.
// - Order bit one shifts MSB first, zero LSB first.
// - Idle level bit one holds the clock low when idle, zero holds it high.
package serial_spi_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFS_MODE_CTRL = 4'h0;
  localparam logic [3:0] OFS_FORMAT = 4'h4;
  localparam logic [3:0] OFS_SHIFT_DATA = 4'h8;
  localparam logic [3:0] OFS_I2C_AUX = 4'hc;
  // serial_mode_control fields
  localparam int MODE_LSB = 5;
  localparam int DBNC_LSB = 2;
  localparam int EN_BIT = 1;
  localparam int ICF_BIT = 0;
  localparam logic [2:0] MODE_RESET = 3'h7;
  // spi_format_flags fields
  localparam int SPARE_LSB = 6;
  localparam int CLOCK_IDLE_LEVEL_SELECT_BIT = 5;
  localparam int CLOCK_EDGE_SELECT_BIT = 4;
  localparam int MLS_BIT = 3;
  localparam int SELECT_PIN_ENABLE_BIT = 2;
  localparam int WRITE_COLLISION_FLAG_BIT = 1;
  localparam int TRF_BIT = 0;
  // i2c_aux_control fields
  localparam int HTX_BIT = 4;
  localparam int ACK_CONTROL_BIT_BIT = 3;
  localparam logic [7:0] I2C_FLAG_MASK = 8'h00e5;
  localparam logic [7:0] I2C_FLAG_DEFAULT = 8'h0081;
  // ****************************************
  // Operating modes
  // ****************************************
  localparam logic [2:0] MODE_DIV4 = 3'h0;
  localparam logic [2:0] MODE_DIV16 = 3'h1;
  localparam logic [2:0] MODE_DIV64 = 3'h2;
  localparam logic [2:0] MODE_SUB = 3'h3;
  localparam logic [2:0] MODE_TIMER = 3'h4;
  localparam logic [2:0] MODE_SLAVE = 3'h5;
  localparam logic [2:0] MODE_I2C = 3'h6;
  // Half periods of the serial clock in system clocks
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] DBNC_NONE = 3'h0;
  localparam logic [2:0] DBNC_TWO = 3'h2;
  localparam logic [2:0] DBNC_FOUR = 3'h4;
  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* design/serial_spi_ctrl.sv */
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module serial_spi_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Master clock sources
  input wire logic sub_clk_edge,
  input wire logic timer_match,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic scs_b_in,
  output logic scs_b_out,
  output logic scs_b_oe,
  // Status to the system
  output logic spi_event,
  output logic module_active,
  output logic [2:0] i2c_debounce_cycles
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_b_ff;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_b_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_b_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [2:0] mode_ff;
  logic [1:0] dbnc_ff;
  logic en_ff;
  logic icf_ff;
  logic [1:0] spare_ff;
  logic clock_idle_level_select_ff;
  logic clock_edge_select_ff;
  logic mls_ff;
  logic select_pin_enable_ff;
  logic write_collision_flag_ff;
  logic trf_ff;
  logic htx_ff;
  logic ack_control_bit_ff;
  logic [7:0] i2c_flags_ff;
  logic [7:0] data_ff;

  // ****************************************
  // Bus slave
  // ****************************************
  logic aw_ok_ff;
  logic w_ok_ff;
  logic [3:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rbyte_ff;

  wire wr_fire = aw_ok_ff & w_ok_ff & ~bvalid_ff;
  wire wr_hit_mode = awaddr_ff == serial_spi_pkg::OFS_MODE_CTRL;
  wire wr_hit_fmt = awaddr_ff == serial_spi_pkg::OFS_FORMAT;
  wire wr_hit_data = awaddr_ff == serial_spi_pkg::OFS_SHIFT_DATA;
  wire wr_hit_aux = awaddr_ff == serial_spi_pkg::OFS_I2C_AUX;
  wire wr_mapped = wr_hit_mode | wr_hit_fmt | wr_hit_data | wr_hit_aux;
  wire wr_mode = wr_fire & wlane_ff & wr_hit_mode;
  wire wr_fmt = wr_fire & wlane_ff & wr_hit_fmt;
  wire wr_data = wr_fire & wlane_ff & wr_hit_data;
  wire wr_aux = wr_fire & wlane_ff & wr_hit_aux;
  wire ar_fire = s_axi_arvalid & ~rvalid_ff;

  // Bit 4 of the mode register is not stored and reads zero
  wire [7:0] mode_rd = {mode_ff, 1'b0, dbnc_ff, en_ff, icf_ff};
  wire [7:0] fmt_rd = {spare_ff, clock_idle_level_select_ff, clock_edge_select_ff, mls_ff, select_pin_enable_ff, write_collision_flag_ff, trf_ff};
  wire [7:0] aux_rd = (i2c_flags_ff & serial_spi_pkg::I2C_FLAG_MASK)
                      | {3'h0, htx_ff, ack_control_bit_ff, 3'h0};
  wire rd_mapped = (s_axi_araddr == serial_spi_pkg::OFS_MODE_CTRL)
                   | (s_axi_araddr == serial_spi_pkg::OFS_FORMAT)
                   | (s_axi_araddr == serial_spi_pkg::OFS_SHIFT_DATA)
                   | (s_axi_araddr == serial_spi_pkg::OFS_I2C_AUX);
  wire [7:0] rd_byte = (s_axi_araddr == serial_spi_pkg::OFS_MODE_CTRL) ? mode_rd :
                       (s_axi_araddr == serial_spi_pkg::OFS_FORMAT) ? fmt_rd :
                       (s_axi_araddr == serial_spi_pkg::OFS_SHIFT_DATA) ? data_ff :
                       (s_axi_araddr == serial_spi_pkg::OFS_I2C_AUX) ? aux_rd : 8'h00;

  assign s_axi_awready = ~aw_ok_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_ok_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h00_0000, rbyte_ff};

  always_ff @(posedge clk_sys or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= serial_spi_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= serial_spi_pkg::RESP_OKAY;
      rbyte_ff <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_ok_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_ok_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? serial_spi_pkg::RESP_OKAY : serial_spi_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_ff <= 1'b1;
        rbyte_ff <= rd_byte;
        rresp_ff <= rd_mapped ? serial_spi_pkg::RESP_OKAY : serial_spi_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Mode decode and clock source
  // ****************************************
  wire is_master = mode_ff <= serial_spi_pkg::MODE_TIMER;
  wire is_slave = mode_ff == serial_spi_pkg::MODE_SLAVE;
  // I2C and the disabled code leave the SPI engine idle
  wire spi_on = en_ff & (is_master | is_slave);
  wire [5:0] half_len = (mode_ff == serial_spi_pkg::MODE_DIV4) ? serial_spi_pkg::HALF_DIV4 :
                        (mode_ff == serial_spi_pkg::MODE_DIV16) ? serial_spi_pkg::HALF_DIV16 :
                        serial_spi_pkg::HALF_DIV64;
  logic [4:0] div_cnt_ff;
  logic busy_ff;
  logic [3:0] edge_idx_ff;
  logic sck_ff;
  logic sck_prev_ff;
  logic sdo_ff;
  logic event_ff;
  logic [2:0] dbnc_cycles_ff;

  wire div_tick = {1'b0, div_cnt_ff} == (half_len - 6'h01);
  // Each pulse of the slow sources is one half period, so the timer rate is halved
  wire half_tick = (mode_ff == serial_spi_pkg::MODE_SUB) ? sub_clk_edge :
                   (mode_ff == serial_spi_pkg::MODE_TIMER) ? timer_match : div_tick;
  wire sck_idle = ~clock_idle_level_select_ff;

  // ****************************************
  // Shift engine
  // ****************************************
  // Select ignored when its pin function is off
  wire selected = ~select_pin_enable_ff | ~scs_b_in;
  wire xfer_busy = busy_ff | (edge_idx_ff != 4'h0);
  wire m_edge = spi_on & is_master & busy_ff & half_tick;
  wire s_edge = spi_on & is_slave & selected & (sck_in != sck_prev_ff);
  wire shift_edge = m_edge | s_edge;
  // Edge selection picks leading or trailing clock edges for sampling
  wire sample = shift_edge & (edge_idx_ff[0] != clock_edge_select_ff);
  wire drive = shift_edge & ~sample;
  wire done = shift_edge & (edge_idx_ff == serial_spi_pkg::LAST_EDGE);
  wire cs_high = spi_on & is_slave & select_pin_enable_ff & scs_b_in;
  wire abort = cs_high & (edge_idx_ff != 4'h0);
  wire start = wr_data & spi_on & is_master & ~xfer_busy;
  wire load = wr_data & ~xfer_busy;
  // Shift order picks which end leaves first and where the input enters
  wire out_bit = mls_ff ? data_ff[7] : data_ff[0];
  wire load_bit = mls_ff ? wbyte_ff[7] : wbyte_ff[0];
  wire [7:0] shifted = mls_ff ? {data_ff[6:0], sdi_in} : {sdi_in, data_ff[7:1]};
  wire en_rise_i2c = wr_mode & wbyte_ff[serial_spi_pkg::EN_BIT] & ~en_ff
                     & (wbyte_ff[7:5] == serial_spi_pkg::MODE_I2C);

  always_ff @(posedge clk_sys or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      div_cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      edge_idx_ff <= 4'h0;
      sck_ff <= 1'b1;
      sck_prev_ff <= 1'b0;
      sdo_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      div_cnt_ff <= (!busy_ff || div_tick) ? 5'h00 : div_cnt_ff + 5'h01;
      sck_prev_ff <= sck_in;
      event_ff <= done | abort;
      if (!spi_on || cs_high) begin
        edge_idx_ff <= 4'h0;
      end else if (shift_edge) begin
        edge_idx_ff <= edge_idx_ff + 4'h1;
      end
      busy_ff <= spi_on & (start | (busy_ff & ~done));
      if (!spi_on || !is_master || !busy_ff) begin
        sck_ff <= sck_idle;
      end else if (m_edge) begin
        sck_ff <= ~sck_ff;
      end
      if (load) begin
        sdo_ff <= load_bit;
      end else if (drive) begin
        sdo_ff <= out_bit;
      end
    end
  end

  // Received and loaded bytes share one register, left without reset
  always_ff @(posedge clk_sys) begin
    if (sample) begin
      data_ff <= shifted;
    end else if (load) begin
      data_ff <= wbyte_ff;
    end
  end

  // ****************************************
  // Control registers and flags
  // ****************************************
  // Hardware sets win over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      mode_ff <= serial_spi_pkg::MODE_RESET;
      dbnc_ff <= 2'h0;
      en_ff <= 1'b0;
      icf_ff <= 1'b0;
      spare_ff <= 2'h0;
      clock_idle_level_select_ff <= 1'b0;
      clock_edge_select_ff <= 1'b0;
      mls_ff <= 1'b0;
      select_pin_enable_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      trf_ff <= 1'b0;
      htx_ff <= 1'b0;
      ack_control_bit_ff <= 1'b0;
      i2c_flags_ff <= serial_spi_pkg::I2C_FLAG_DEFAULT;
      dbnc_cycles_ff <= serial_spi_pkg::DBNC_NONE;
    end else begin
      if (wr_mode) begin
        mode_ff <= wbyte_ff[7:5];
        dbnc_ff <= wbyte_ff[3:2];
        en_ff <= wbyte_ff[serial_spi_pkg::EN_BIT];
      end
      // Software may set this flag alone, without the complete flag
      icf_ff <= abort | (wr_mode ? wbyte_ff[serial_spi_pkg::ICF_BIT] : icf_ff);
      // Format bits are not touched by enable changes
      if (wr_fmt) begin
        spare_ff <= wbyte_ff[7:6];
        clock_idle_level_select_ff <= wbyte_ff[serial_spi_pkg::CLOCK_IDLE_LEVEL_SELECT_BIT];
        clock_edge_select_ff <= wbyte_ff[serial_spi_pkg::CLOCK_EDGE_SELECT_BIT];
        mls_ff <= wbyte_ff[serial_spi_pkg::MLS_BIT];
        select_pin_enable_ff <= wbyte_ff[serial_spi_pkg::SELECT_PIN_ENABLE_BIT];
      end
      write_collision_flag_ff <= (wr_data & xfer_busy) | (wr_fmt ? wbyte_ff[serial_spi_pkg::WRITE_COLLISION_FLAG_BIT] : write_collision_flag_ff);
      trf_ff <= done | abort | (wr_fmt ? wbyte_ff[serial_spi_pkg::TRF_BIT] : trf_ff);
      if (wr_aux) begin
        htx_ff <= wbyte_ff[serial_spi_pkg::HTX_BIT];
        ack_control_bit_ff <= wbyte_ff[serial_spi_pkg::ACK_CONTROL_BIT_BIT];
      end
      if (en_rise_i2c) begin
        i2c_flags_ff <= serial_spi_pkg::I2C_FLAG_DEFAULT;
      end
      dbnc_cycles_ff <= dbnc_ff[1] ? serial_spi_pkg::DBNC_FOUR :
                        dbnc_ff[0] ? serial_spi_pkg::DBNC_TWO : serial_spi_pkg::DBNC_NONE;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // Every pin is released while the interface is off
  assign sck_out = sck_ff;
  assign sck_oe = spi_on & is_master;
  assign sdo_out = sdo_ff;
  assign sdo_oe = spi_on & (is_master | selected);
  assign scs_b_out = ~busy_ff;
  assign scs_b_oe = spi_on & is_master & select_pin_enable_ff;
  assign spi_event = event_ff;
  assign module_active = en_ff;
  assign i2c_debounce_cycles = dbnc_cycles_ff;
endmodule

/* verification/serial_spi_ctrl_assertions.sv */
`timescale 1ns/1ps
module serial_spi_ctrl_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Observed ports
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic scs_b_out,
  input wire logic scs_b_oe,
  input wire logic spi_event,
  input wire logic module_active,
  input wire logic [2:0] i2c_debounce_cycles
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // Clock edges of the current master byte
  // ****************************************
  // Idle-level changes outside a frame are not counted
  logic [4:0] edge_cnt_ff;
  logic sck_prev_ff;
  logic scs_prev_ff;
  logic [4:0] nxt_edge_cnt;
  logic frame_edge;
  assign frame_edge = (sck_out != sck_prev_ff) && !(scs_b_out && scs_prev_ff);
  assign nxt_edge_cnt = spi_event ? 5'h00 : (frame_edge ? edge_cnt_ff + 5'h01 : edge_cnt_ff);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt_ff <= 5'h00;
      sck_prev_ff <= 1'b1;
      scs_prev_ff <= 1'b1;
    end else begin
      edge_cnt_ff <= nxt_edge_cnt;
      sck_prev_ff <= sck_out;
      scs_prev_ff <= scs_b_out;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  chk_pins_off: assert property (!module_active [*2] |-> !sck_oe && !sdo_oe && !scs_b_oe)
    else $error("serial pins driven while disabled");
  chk_dbnc_legal: assert property (i2c_debounce_cycles inside {3'h0, 3'h2, 3'h4})
    else $error("illegal debounce length");
  chk_event_single: assert property (spi_event |=> !spi_event)
    else $error("event longer than one cycle");
  chk_sck_needs_en: assert property (sck_oe |-> module_active)
    else $error("clock driven while disabled");
  chk_sel_with_clk: assert property (scs_b_oe |-> sck_oe)
    else $error("select driven outside master mode");
  // The sixteenth edge is still in flight when the event shows
  chk_byte_edges: assert property (spi_event && sck_oe |-> edge_cnt_ff + {4'h0, frame_edge} == 5'h10)
    else $error("master byte without sixteen clock edges");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  cov_master_done: cover property (spi_event && sck_oe);
  cov_slave_done: cover property (spi_event && !sck_oe);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind serial_spi_ctrl serial_spi_ctrl_checker serial_spi_ctrl_checker_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe), .scs_b_out(scs_b_out),
  .scs_b_oe(scs_b_oe), .spi_event(spi_event), .module_active(module_active),
  .i2c_debounce_cycles(i2c_debounce_cycles));

/* verification/spi_peer_model.sv */
`timescale 1ns/1ps
module spi_peer_model (
  // Serial pins
  input wire logic sck,
  input wire logic cs_b,
  input wire logic mosi,
  output logic miso,
  // Frame setup
  input wire logic lead_sample,
  input wire logic msb_first,
  input wire logic idle_lvl,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  int idx;
  int nrx;
  function automatic logic pick(input int i);
    return tx_byte[msb_first ? 7 - i : i];
  endfunction
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  initial nrx = 8;
  // With trailing capture the first bit only appears at the first leading edge
  always @(negedge cs_b) begin
    idx = lead_sample ? 0 : -1;
    nrx = 0;
    #1 miso = lead_sample ? pick(0) : ~miso;
  end
  // Deselected line never keeps the last bit
  always @(posedge cs_b) miso = ~miso;
  always @(sck) begin
    // With trailing capture the last capture edge and select release share a time step, so captures are counted, not gated by select
    if ((sck !== idle_lvl) == lead_sample) begin
      if (nrx < 8) begin
        rx_byte = msb_first ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
        nrx = nrx + 1;
      end
    end else if (!cs_b) begin
      idx = idx + 1;
      #1 miso = (idx < 8) ? pick(idx) : ~miso;
    end
  end
endmodule

/* verification/serial_spi_ctrl_bench.sv */
`timescale 1ns/1ps
module serial_spi_ctrl_bench;
  logic clk_sys, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sub_clk_edge, timer_match;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic sck_out, sck_oe, sdo_out, sdo_oe, scs_b_out, scs_b_oe, spi_event, module_active, miso;
  logic tb_sck, tb_cs_b, p_lead, p_msb, p_idle, last_sck, ev;
  logic [2:0] i2c_debounce_cycles;
  logic [7:0] p_tx, p_rx, run, gap, tx;
  logic [31:0] d;
  int err_count, n_compared;
  serial_spi_ctrl serial_spi_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sub_clk_edge(sub_clk_edge), .timer_match(timer_match),
    .sck_in(sck_oe ? sck_out : tb_sck), .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(miso), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .scs_b_in(scs_b_oe ? scs_b_out : tb_cs_b), .scs_b_out(scs_b_out), .scs_b_oe(scs_b_oe),
    .spi_event(spi_event), .module_active(module_active), .i2c_debounce_cycles(i2c_debounce_cycles));
  spi_peer_model spi_peer_model_inst (.sck(sck_out), .cs_b(scs_b_out), .mosi(sdo_out), .miso(miso),
    .lead_sample(p_lead), .msb_first(p_msb), .idle_lvl(p_idle), .tx_byte(p_tx), .rx_byte(p_rx));
  // ****************************************
  // Clock, pulse sources and edge spacing
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial run = 8'h00;
  initial gap = 8'h00;
  initial last_sck = 1'b1;
  always @(posedge clk_sys) begin
    sub_clk_edge <= ($urandom % 4) == 0;
    timer_match <= ($urandom % 4) == 0;
    run <= run + 8'h01;
    last_sck <= sck_out;
    if (sck_out !== last_sck) begin
      gap <= run;
      run <= 8'h01;
    end
  end
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0000_0000, {30'h0000_0000, s_axi_bresp});
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
    rd(a);
    chk(nm, {24'h00_0000, e}, d);
  endtask
  function automatic logic [7:0] mw(input logic [2:0] m, input logic [1:0] db, input logic en);
    return {m, 1'b0, db, en, 1'b0};
  endfunction
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1500000;
    err_count++;
    final_report();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, sub_clk_edge, timer_match, s_axi_wdata} = 42'h000_0000_0000;
    {s_axi_wstrb, tb_sck, tb_cs_b, p_lead, p_msb, p_idle, p_tx} = 17'h1_ef00;
    err_count = 0;
    n_compared = 0;
    void'($urandom(32'ha98c));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(serial_spi_pkg::OFS_MODE_CTRL, 8'he0, "mode_reset");
    rdc(serial_spi_pkg::OFS_FORMAT, 8'h00, "format_reset");
    rd(4'h2);
    chk("unmapped_resp", 32'h0000_0002, {30'h0000_0000, r});
    for (int i = 0; i < 4; i++) begin
      wr(serial_spi_pkg::OFS_MODE_CTRL, mw(3'h7, i[1:0], 1'b0) | 8'h10);
      rdc(serial_spi_pkg::OFS_MODE_CTRL, mw(3'h7, i[1:0], 1'b0), "mode_bit4");
      chk("debounce", (i == 0) ? 0 : ((i == 1) ? 2 : 4), {29'h0000_0000, i2c_debounce_cycles});
    end
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 2; k++) begin
        {p_idle, p_lead, p_msb} = $urandom;
        p_tx = $urandom;
        tx = $urandom;
        wr(serial_spi_pkg::OFS_FORMAT, {2'h0, ~p_idle, p_lead, p_msb, 3'h4});
        wr(serial_spi_pkg::OFS_MODE_CTRL, mw(m[2:0], 2'h0, 1'b1));
        wr(serial_spi_pkg::OFS_SHIFT_DATA, tx);
        if (m == 2 && k == 0) wr(serial_spi_pkg::OFS_SHIFT_DATA, ~tx);
        for (int t = 0; t < 300 && d[0] !== 1'b1; t++) rd(serial_spi_pkg::OFS_FORMAT);
        chk("complete", 1, d[0]);
        chk("collision", (m == 2 && k == 0), d[1]);
        if (m < 3) chk("half_period", 2 << (2 * m), gap);
        rdc(serial_spi_pkg::OFS_SHIFT_DATA, p_tx, "received");
        chk("sent", tx, p_rx);
        wr(serial_spi_pkg::OFS_FORMAT, 8'h00);
        d = 32'h0000_0000;
      end
    end
    wr(serial_spi_pkg::OFS_FORMAT, 8'h04);
    wr(serial_spi_pkg::OFS_MODE_CTRL, mw(serial_spi_pkg::MODE_SLAVE, 2'h0, 1'b1));
    tb_cs_b <= 1'b0;
    repeat (3) begin
      repeat (4) @(posedge clk_sys);
      tb_sck <= ~tb_sck;
    end
    repeat (4) @(posedge clk_sys);
    tb_cs_b <= 1'b1;
    ev = 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      ev = ev | spi_event;
    end
    chk("slave_event", 1, ev);
    rdc(serial_spi_pkg::OFS_MODE_CTRL, 8'ha3, "incomplete");
    rdc(serial_spi_pkg::OFS_FORMAT, 8'h05, "slave_complete");
    wr(serial_spi_pkg::OFS_FORMAT, 8'h04);
    wr(serial_spi_pkg::OFS_MODE_CTRL, 8'ha3);
    rdc(serial_spi_pkg::OFS_FORMAT, 8'h04, "soft_incomplete");
    wr(serial_spi_pkg::OFS_MODE_CTRL, mw(3'h0, 2'h0, 1'b0));
    chk("disabled_clock", 0, sck_oe);
    chk("disabled_active", 0, module_active);
    wr(serial_spi_pkg::OFS_FORMAT, 8'h2c);
    wr(serial_spi_pkg::OFS_I2C_AUX, 8'h00);
    wr(serial_spi_pkg::OFS_MODE_CTRL, mw(3'h0, 2'h0, 1'b1));
    rdc(serial_spi_pkg::OFS_FORMAT, 8'h2c, "kept_format");
    wr(serial_spi_pkg::OFS_I2C_AUX, 8'h18);
    wr(serial_spi_pkg::OFS_MODE_CTRL, mw(serial_spi_pkg::MODE_I2C, 2'h0, 1'b0));
    wr(serial_spi_pkg::OFS_MODE_CTRL, mw(serial_spi_pkg::MODE_I2C, 2'h0, 1'b1));
    rdc(serial_spi_pkg::OFS_I2C_AUX, 8'h99, "i2c_kept");
    final_report();
  end
endmodule
